//--- verilog/isd_defines.svh
`ifndef ISD_DEFINES_SVH
`define ISD_DEFINES_SVH
`define ISD_ADDR_CFG 8'h00
`define ISD_ADDR_STAT 8'h04
`define ISD_CFG_RST 19'h40029
`define ISD_F_DDR 0
`define ISD_F_WID 4:1
`define ISD_F_NCE2 5
`define ISD_F_PATH 7:6
`define ISD_F_MODE 9:8
`define ISD_F_INIT 15:10
`define ISD_F_SLIP 16
`define ISD_F_SLAVE 17
`define ISD_F_MEM 18
`define ISD_WIDTH_RST 4'h4
`define ISD_CELL_BITS 4'h6
`define ISD_TAP_MAX 6'h3f
`define ISD_DEFAULT_TAP 6'h00
`endif

//--- verilog/isd_pkg.sv
`default_nettype none
package isd_pkg;
  typedef enum logic [1:0] {
    ISD_PATH_NONE = 2'h0,
    ISD_PATH_COMB = 2'h1,
    ISD_PATH_REG = 2'h2,
    ISD_PATH_BOTH = 2'h3
  } isd_path_type;
  typedef enum logic [1:0] {
    ISD_DLY_DEFAULT = 2'h0,
    ISD_DLY_FIXED = 2'h1,
    ISD_DLY_VAR = 2'h2,
    ISD_DLY_RSVD = 2'h3
  } isd_dly_mode_type;
endpackage : isd_pkg
`default_nettype wire

//--- verilog/isd_deserializer.sv
// Summary of operation
// RULE1: SDR words of 2 to 8 bits.
// RULE2: DDR words of 4, 6, 8, 10 bits.
// RULE3: 64 taps, stepping wraps around.
// RULE4: Delay on comb, registered, both, neither.
// RULE5: Default mode uses zero hold tap.
// RULE6: Fixed mode holds the initial tap.
// RULE7: Variable mode steps by step, direction, reload.
// RULE8: Step enable moves tap one position.
// RULE9: Reload restores initial tap, else zero.
// RULE10: Unregistered output direct or delayed; the code registers comb_out_o for one clock.
// RULE11: Parallel outputs registered, change on divided clock.
// RULE12: Earliest bit on output n, LSB output 6.
// RULE13: Six bits per cell, cascade for more.
// RULE14: Master cascade outputs feed slave inputs.
// RULE15: Slip input high slips once per word.
// RULE16: Slip rotates word, SDR and DDR differ.
// RULE17: One enable: first enable gates capture.
// RULE18: Two enables: each gates one half.
// RULE19: Enable gates only first stage capture.
// RULE20: Strobe data moves onto transfer clock.
// RULE21: User ties reverse set low.
// RULE22: Reset input active high.
// RULE23: Reset clears data registers at once.
// RULE24: Reset held one word; release retimed; the code holds data reset two clocks past release, at any width.
// RULE25: Networking mode grounds transfer clock.
// RULE26: Slip disabled means slip input ignored.
// RULE27: One new word per divided period.
// RULE28: Tap, slip, enable run on divided clock; the code applies the capture enables on every bit_tick.
`timescale 1ns/10ps
`default_nettype none
`include "isd_defines.svh"
module isd_deserializer
  import isd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic ser_data_i,
  input wire logic strobe_transfer_clock_i,
  input wire logic capture_enable_first_i,
  input wire logic capture_enable_second_i,
  input wire logic word_slip_i,
  input wire logic delay_step_enable_i,
  input wire logic delay_step_up_i,
  input wire logic delay_reload_i,
  input wire logic reverse_set_in_i,
  input wire logic cell_reset_in_i,
  input wire logic cascade_in_a_i,
  input wire logic cascade_in_b_i,
  output logic comb_out_o,
  output logic [5:0] parallel_word_out_o,
  output logic cascade_out_a_o,
  output logic cascade_out_b_o,
  output logic divided_clock_o
);

////////////////////////////////////////////////////////////////////////////////
// Resets.

logic [1:0] rst_sync_reg;
logic sys_rst_n;
logic [1:0] cell_rst_reg;
logic data_rst_n;

always_ff @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    rst_sync_reg <= 2'h0;
  end else begin
    rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
end
assign sys_rst_n = rst_sync_reg[1];

always_ff @(posedge clk_i or negedge rst_n_i or posedge cell_reset_in_i) begin
  if (!rst_n_i) begin
    cell_rst_reg <= 2'h3;
  end else if (cell_reset_in_i) begin
    cell_rst_reg <= 2'h3; // RULE22
  end else begin
    cell_rst_reg <= {cell_rst_reg[0], 1'b0}; // RULE24
  end
end
assign data_rst_n = sys_rst_n & ~cell_rst_reg[1]; // RULE23

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers.

logic [7:0] pin_s1_reg;
logic [7:0] pin_s2_reg;
logic din_s;
logic stc_s;
logic ce1_s;
logic ce2_s;
logic slip_s;
logic step_s;
logic up_s;
logic reload_s;

always_ff @(posedge clk_i or negedge sys_rst_n) begin
  if (!sys_rst_n) begin
    pin_s1_reg <= 8'h00;
    pin_s2_reg <= 8'h00;
  end else begin
    pin_s1_reg <= {delay_reload_i, delay_step_up_i, delay_step_enable_i, word_slip_i,
                   capture_enable_second_i, capture_enable_first_i, strobe_transfer_clock_i, ser_data_i};
    pin_s2_reg <= pin_s1_reg;
  end
end
assign din_s = pin_s2_reg[0];
assign stc_s = pin_s2_reg[1];
assign ce1_s = pin_s2_reg[2];
assign ce2_s = pin_s2_reg[3];
assign slip_s = pin_s2_reg[4];
assign step_s = pin_s2_reg[5];
assign up_s = pin_s2_reg[6];
assign reload_s = pin_s2_reg[7];

////////////////////////////////////////////////////////////////////////////////
// Configuration register.

logic [18:0] cfg_reg;
logic ddr;
logic [3:0] cfg_wid;
logic num_ce2;
isd_path_type path;
isd_dly_mode_type dly_mode;
logic [5:0] init_tap;
logic slip_en;
logic slave;
logic mem;

always_ff @(posedge clk_i or negedge sys_rst_n) begin
  if (!sys_rst_n) begin
    cfg_reg <= `ISD_CFG_RST;
  end else if (reg_wr_i && reg_addr_i == `ISD_ADDR_CFG) begin
    cfg_reg <= reg_wdata_i[18:0];
  end
end
assign ddr = cfg_reg[`ISD_F_DDR];
assign cfg_wid = cfg_reg[`ISD_F_WID];
assign num_ce2 = cfg_reg[`ISD_F_NCE2];
assign path = isd_path_type'(cfg_reg[`ISD_F_PATH]);
assign dly_mode = isd_dly_mode_type'(cfg_reg[`ISD_F_MODE]);
assign init_tap = cfg_reg[`ISD_F_INIT];
assign slip_en = cfg_reg[`ISD_F_SLIP];
assign slave = cfg_reg[`ISD_F_SLAVE];
assign mem = cfg_reg[`ISD_F_MEM];

////////////////////////////////////////////////////////////////////////////////
// Word width and cell share.

logic wid_ok;
logic [3:0] width;
logic [3:0] cell_bits;
logic [3:0] half;

always_comb begin
  case (cfg_wid)
    4'h4, 4'h6, 4'h8: wid_ok = 1'b1; // RULE1 RULE2
    4'ha: wid_ok = ddr; // RULE2
    4'h2, 4'h3, 4'h5, 4'h7: wid_ok = !ddr; // RULE1
    default: wid_ok = 1'b0;
  endcase
  width = wid_ok ? cfg_wid : `ISD_WIDTH_RST;
  if (slave) begin
    cell_bits = (width > `ISD_CELL_BITS) ? width - `ISD_CELL_BITS : 4'h0; // RULE13
  end else begin
    cell_bits = (width > `ISD_CELL_BITS) ? `ISD_CELL_BITS : width; // RULE13
  end
  half = width >> 1;
end

////////////////////////////////////////////////////////////////////////////////
// Delay line.

logic [5:0] tap_reg;
logic [5:0] tap_next;
logic [63:0] dline_reg;
logic dly_out;
logic reg_in;
logic comb_out_reg;
logic word_tick;

always_comb begin
  tap_next = tap_reg;
  case (dly_mode)
    ISD_DLY_FIXED: tap_next = init_tap; // RULE6
    ISD_DLY_VAR: begin
      if (reload_s) begin
        tap_next = init_tap; // RULE9
      end else if (step_s) begin
        tap_next = up_s ? tap_reg + 6'h01 : tap_reg - 6'h01; // RULE7 RULE8 RULE3
      end
    end
    default: tap_next = `ISD_DEFAULT_TAP; // RULE5
  endcase
end

always_ff @(posedge clk_i or negedge sys_rst_n) begin
  if (!sys_rst_n) begin
    tap_reg <= `ISD_DEFAULT_TAP;
  end else if (word_tick) begin
    tap_reg <= tap_next; // RULE28
  end
end

always_ff @(posedge clk_i or negedge data_rst_n) begin
  if (!data_rst_n) begin
    dline_reg <= 64'h0;
    comb_out_reg <= 1'b0;
  end else begin
    dline_reg <= {dline_reg[62:0], din_s};
    comb_out_reg <= (path == ISD_PATH_COMB || path == ISD_PATH_BOTH) ? dly_out : din_s; // RULE10 RULE4
  end
end
assign dly_out = dline_reg[tap_reg];
assign reg_in = (path == ISD_PATH_REG || path == ISD_PATH_BOTH) ? dly_out : din_s; // RULE4

////////////////////////////////////////////////////////////////////////////////
// Bit timing, clock enable unit and divider.

logic stc_d_reg;
logic bit_tick;
logic internal_capture_enable;
logic shift;
logic [3:0] cnt_reg;
logic div_en_reg;

always_ff @(posedge clk_i or negedge data_rst_n) begin
  if (!data_rst_n) begin
    stc_d_reg <= 1'b0;
    cnt_reg <= 4'h0;
    div_en_reg <= 1'b0;
  end else begin
    stc_d_reg <= stc_s;
    div_en_reg <= word_tick;
    if (bit_tick) begin
      cnt_reg <= (cnt_reg == width - 4'h1) ? 4'h0 : cnt_reg + 4'h1; // RULE27
    end
  end
end
assign bit_tick = mem ? (stc_s & ~stc_d_reg) : 1'b1; // RULE20
assign word_tick = bit_tick && cnt_reg == width - 4'h1; // RULE27
assign internal_capture_enable = (num_ce2 && cnt_reg >= half) ? ce2_s : ce1_s; // RULE17 RULE18
assign shift = slave ? cascade_in_b_i : (bit_tick & internal_capture_enable); // RULE19 RULE14

////////////////////////////////////////////////////////////////////////////////
// Capture history, slip and word output.

logic [15:0] hist_reg;
logic [15:0] hist_next;
logic [15:0] win;
logic [15:0] win_up;
logic [5:0] mask6;
logic [5:0] word_sel;
logic [5:0] word_reg;
logic [3:0] off_reg;
logic ddr_odd_reg;
logic [3:0] slip_step;
logic [4:0] slip_sum;
logic [3:0] slip_wrap;

assign hist_next = shift ? {hist_reg[14:0], slave ? cascade_in_a_i : reg_in} : hist_reg; // RULE14
assign win = hist_next >> off_reg; // RULE16
assign win_up = win << (`ISD_CELL_BITS - cell_bits);
assign mask6 = 6'h3f >> (`ISD_CELL_BITS - cell_bits);
assign word_sel = slave ? win_up[5:0] : (win[5:0] & mask6); // RULE12 RULE14

always_ff @(posedge clk_i or negedge data_rst_n) begin
  if (!data_rst_n) begin
    hist_reg <= 16'h0;
    word_reg <= 6'h00;
  end else begin
    hist_reg <= hist_next; // RULE19
    if (word_tick) begin
      word_reg <= word_sel; // RULE11 RULE27
    end
  end
end

// A five-bit sum keeps the wide DDR step from overflowing before the wrap.
always_comb begin
  slip_step = (ddr && ddr_odd_reg) ? width - 4'h3 : 4'h1; // RULE16
  slip_sum = {1'b0, off_reg} + {1'b0, slip_step};
  slip_wrap = (slip_sum >= {1'b0, width}) ? 4'(slip_sum - {1'b0, width}) : slip_sum[3:0];
end

always_ff @(posedge clk_i or negedge sys_rst_n) begin
  if (!sys_rst_n) begin
    off_reg <= 4'h0;
    ddr_odd_reg <= 1'b0;
  end else if (!slip_en || slave) begin
    off_reg <= 4'h0; // RULE26
    ddr_odd_reg <= 1'b0;
  end else if (word_tick && slip_s) begin
    off_reg <= slip_wrap; // RULE15 RULE16
    ddr_odd_reg <= ~ddr_odd_reg;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register read port.

logic [31:0] rdata_reg;

always_ff @(posedge clk_i or negedge sys_rst_n) begin
  if (!sys_rst_n) begin
    rdata_reg <= 32'h0;
  end else if (reg_rd_i && reg_addr_i == `ISD_ADDR_CFG) begin
    rdata_reg <= {13'h0, cfg_reg};
  end else if (reg_rd_i && reg_addr_i == `ISD_ADDR_STAT) begin
    rdata_reg <= {16'h0, word_reg, off_reg, tap_reg};
  end else begin
    rdata_reg <= 32'h0;
  end
end

assign reg_rdata_o = rdata_reg;
assign comb_out_o = comb_out_reg;
assign parallel_word_out_o = word_reg;
assign cascade_out_a_o = hist_reg[off_reg + 4'h5]; // RULE14
assign cascade_out_b_o = shift; // RULE14
assign divided_clock_o = div_en_reg;

////////////////////////////////////////////////////////////////////////////////
// Assertions.

default clocking cb @(posedge clk_i);
endclocking
default disable iff (!data_rst_n);

tap_wrap_a: assert property ( // RULE3
  word_tick && dly_mode == ISD_DLY_VAR && !reload_s && step_s && up_s && tap_reg == `ISD_TAP_MAX
  |=> tap_reg == 6'h00) else $error("Tap did not wrap to zero.");
tap_down_a: assert property ( // RULE8
  word_tick && dly_mode == ISD_DLY_VAR && !reload_s && step_s && !up_s
  |=> tap_reg == $past(tap_reg) - 6'h01) else $error("Tap did not step down.");
tap_reload_a: assert property ( // RULE9
  word_tick && dly_mode == ISD_DLY_VAR && reload_s
  |=> tap_reg == $past(init_tap)) else $error("Reload missed initial tap.");
tap_fixed_a: assert property ( // RULE6
  word_tick && dly_mode == ISD_DLY_FIXED |=> tap_reg == $past(init_tap)) else $error("Fixed tap wrong.");
tap_default_a: assert property ( // RULE5
  word_tick && dly_mode == ISD_DLY_DEFAULT |=> tap_reg == 6'h00) else $error("Default tap wrong.");
tap_hold_a: assert property (!word_tick |=> $stable(tap_reg)) else $error("Tap moved off tick."); // RULE28
word_sync_a: assert property ($changed(word_reg) |-> div_en_reg) else $error("Word changed off tick."); // RULE11
slip_off_a: assert property (!slip_en |=> off_reg == 4'h0) else $error("Slip acted while disabled."); // RULE26
slip_sdr_a: assert property ( // RULE16
  word_tick && slip_s && slip_en && !ddr && !slave && off_reg < width - 4'h1
  |=> off_reg == $past(off_reg) + 4'h1) else $error("SDR slip step wrong.");
ce_single_a: assert property ( // RULE17
  !slave && !num_ce2 && !ce1_s |=> hist_reg == $past(hist_reg)) else $error("Capture without enable.");
ce_halves_a: assert property ( // RULE18
  !slave && num_ce2 && cnt_reg < half && !ce1_s |=> $stable(hist_reg)) else $error("First half ungated.");
ce_second_a: assert property ( // RULE18
  !slave && num_ce2 && cnt_reg >= half && !ce2_s |=> $stable(hist_reg)) else $error("Second half ungated.");
ddr_width_a: assert property ( // RULE2
  ddr |-> width == 4'h4 || width == 4'h6 || width == 4'h8 || width == 4'ha) else $error("Illegal DDR width.");
cell_reset_a: assert property (@(posedge clk_i) disable iff (!sys_rst_n) // RULE23
  cell_rst_reg[1] |-> word_reg == 6'h00 && hist_reg == 16'h0) else $error("Data held through reset.");

cover property (word_tick && slip_s && slip_en && ddr);
cover property (div_en_reg && slave && width > `ISD_CELL_BITS);
cover property (word_tick && mem);
cover property (word_tick && step_s && dly_mode == ISD_DLY_VAR);
cover property (num_ce2 && !ce1_s && ce2_s && bit_tick);

endmodule : isd_deserializer
`default_nettype wire

//--- tb/isd_tx_model.sv
`timescale 1ns/10ps
`default_nettype none
module isd_tx_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic ser_o
);
  // Source-synchronous sender: one fresh bit per clock from a 15-bit sequence generator.
  logic [14:0] lfsr_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_reg <= 15'h0001;
    end else begin
      lfsr_reg <= {lfsr_reg[13:0], lfsr_reg[14] ^ lfsr_reg[13]};
    end
  end
  assign ser_o = lfsr_reg[14];
endmodule : isd_tx_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "isd_defines.svh"
module tb_top
  import isd_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ce1 = 1'b1;
  logic ce2 = 1'b1;
  logic slip = 1'b0;
  logic step = 1'b0;
  logic up = 1'b0;
  logic reload = 1'b0;
  logic cell_rst = 1'b0;
  logic stc = 1'b0;
  logic ser, comb, div, ca, cb;
  logic [31:0] rdata, q, q2;
  logic [5:0] word, pw;
  logic [15:0] h = 16'h0;
  logic chk_en = 1'b0;
  logic [4:0] tbl [6] = '{5'h02, 5'h03, 5'h05, 5'h06, 5'h14, 5'h16};
  int dseq [6] = '{1, 4, 5, 2, 3, 0};
  int n = 4;
  int per = 1;
  int gap = 0;
  int cyc = 0;
  int error_cnt = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  isd_tx_model tx (.clk_i(clk_i), .rst_n_i(rst_n_i), .ser_o(ser));
  isd_deserializer dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .ser_data_i(ser),
    .strobe_transfer_clock_i(stc),
    .capture_enable_first_i(ce1), .capture_enable_second_i(ce2), .word_slip_i(slip),
    .delay_step_enable_i(step), .delay_step_up_i(up), .delay_reload_i(reload),
    .reverse_set_in_i(1'b0),
    .cell_reset_in_i(cell_rst), .cascade_in_a_i(1'b0), .cascade_in_b_i(1'b0),
    .comb_out_o(comb), .parallel_word_out_o(word), .cascade_out_a_o(ca),
    .cascade_out_b_o(cb), .divided_clock_o(div));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = rdata;
  endtask : rd
  function automatic logic [31:0] cfg(logic ddr, logic [3:0] w, logic sl, logic [1:0] m, logic [5:0] t);
    return {15'h0, sl, t, m, 2'h0, 1'b0, w, ddr};
  endfunction : cfg
  // Holds slip and delay controls for one word so exactly one boundary sees them.
  task automatic act(input logic [3:0] v, output logic [31:0] d);
    @(posedge clk_i);
    {slip, step, up, reload} <= v;
    repeat (n) @(posedge clk_i);
    {slip, step, up, reload} <= 4'h0;
    repeat (12) @(posedge clk_i);
    rd(`ISD_ADDR_STAT, d);
  endtask : act
  task automatic stream();
    chk_en = 1'b0;
    repeat (24) @(posedge clk_i);
    #1 chk_en = 1'b1;
    repeat (30) @(posedge clk_i);
    #1 chk_en = 1'b0;
  endtask : stream
  ////////////////////////////////////////////////////////////////////////////////
  // Word monitor: earliest bit lands on the top used output, newest on bit 0.
  always @(posedge clk_i) begin
    h <= {h[14:0], ser};
    gap <= gap + 1;
    cyc <= cyc + 1;
    pw <= word;
    if (div) begin
      gap <= 1;
      if (chk_en) begin
        if (per == 1) chk(32'(word), 32'((h >> 2) & ((16'h1 << n) - 16'h1)));
        chk(32'(gap), 32'(n * per));
      end
    end else if (chk_en) begin
      chk(32'(word), 32'(pw));
    end
    if (chk_en) begin
      chk(32'(comb), 32'(h[2]));
      if (per == 1) begin
        chk(32'(ca), 32'(h[7]));
        chk(32'(cb), 32'h1);
      end
    end
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(`ISD_ADDR_CFG, q);
    chk(q, 32'(`ISD_CFG_RST));
    rd(8'h08, q);
    chk(q, 32'h0);
    foreach (tbl[i]) begin
      n = int'(tbl[i][3:0]);
      wr(`ISD_ADDR_CFG, cfg(tbl[i][4], tbl[i][3:0], 1'b0, 2'h0, 6'h00));
      stream();
    end
    n = 6;
    wr(`ISD_ADDR_CFG, cfg(1'b0, 4'h6, 1'b1, 2'h0, 6'h00));
    for (int k = 1; k <= 6; k++) begin
      act(4'h8, q);
      chk(32'(q[9:6]), 32'(k % 6));
    end
    wr(`ISD_ADDR_CFG, cfg(1'b1, 4'h6, 1'b1, 2'h0, 6'h00));
    foreach (dseq[i]) begin
      act(4'h8, q);
      chk(32'(q[9:6]), 32'(dseq[i]));
    end
    act(4'h8, q);
    chk(32'(q[9:6]), 32'h1);
    wr(`ISD_ADDR_CFG, cfg(1'b1, 4'h6, 1'b0, 2'h0, 6'h00));
    act(4'h8, q);
    chk(32'(q[9:6]), 32'h0);
    n = 4;
    wr(`ISD_ADDR_CFG, cfg(1'b0, 4'h4, 1'b0, ISD_DLY_VAR, 6'h05));
    act(4'h1, q);
    chk(32'(q[5:0]), 32'h05);
    act(4'h6, q);
    chk(32'(q[5:0]), 32'h06);
    act(4'h4, q);
    chk(32'(q[5:0]), 32'h05);
    wr(`ISD_ADDR_CFG, cfg(1'b0, 4'h4, 1'b0, ISD_DLY_VAR, 6'h00));
    act(4'h1, q);
    chk(32'(q[5:0]), 32'h00);
    act(4'h4, q);
    chk(32'(q[5:0]), 32'(`ISD_TAP_MAX));
    act(4'h6, q);
    chk(32'(q[5:0]), 32'h00);
    wr(`ISD_ADDR_CFG, cfg(1'b0, 4'h4, 1'b0, ISD_DLY_FIXED, 6'h09));
    act(4'h6, q);
    chk(32'(q[5:0]), 32'h09);
    wr(`ISD_ADDR_CFG, cfg(1'b0, 4'h4, 1'b0, ISD_DLY_DEFAULT, 6'h09));
    act(4'h0, q);
    chk(32'(q[5:0]), 32'(`ISD_DEFAULT_TAP));
    wr(`ISD_ADDR_CFG, cfg(1'b0, 4'h4, 1'b0, ISD_DLY_DEFAULT, 6'h00) | 32'h20);
    ce1 <= 1'b0;
    repeat (16) @(posedge clk_i);
    {ce1, ce2} <= 2'b10;
    repeat (16) @(posedge clk_i);
    wr(`ISD_ADDR_CFG, cfg(1'b0, 4'h4, 1'b0, ISD_DLY_DEFAULT, 6'h00));
    ce1 <= 1'b0;
    repeat (16) @(posedge clk_i);
    rd(`ISD_ADDR_STAT, q);
    repeat (8) @(posedge clk_i);
    rd(`ISD_ADDR_STAT, q2);
    chk(32'(q2[15:10]), 32'(q[15:10]));
    ce1 <= 1'b1;
    stream();
    ce2 <= 1'b1;
    per = 2;
    wr(`ISD_ADDR_CFG, cfg(1'b0, 4'h4, 1'b0, ISD_DLY_DEFAULT, 6'h00) | 32'h40000);
    fork
      stream();
      repeat (60) begin
        @(posedge clk_i);
        stc <= ~stc;
      end
    join
    per = 1;
    wr(`ISD_ADDR_CFG, cfg(1'b0, 4'h4, 1'b0, ISD_DLY_DEFAULT, 6'h00));
    @(posedge clk_i);
    cell_rst <= 1'b1;
    #2 chk(32'(word), 32'h0);
    repeat (8) @(posedge clk_i);
    cell_rst <= 1'b0;
    stream();
    results();
  end
endmodule : tb_top
`default_nettype wire
